// ===== hw/wk_pkg.sv
// Shared constants, types and helpers for the wake packet detector
package wk_pkg;

  // APB geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int REG_W  = 16;

  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_BMC      = 10'h000;
  localparam logic [9:0] IDX_RX_CFG   = 10'h134;
  localparam logic [9:0] IDX_RX_STS   = 10'h135;
  localparam logic [9:0] IDX_STA0     = 10'h136;
  localparam logic [9:0] IDX_STA2     = 10'h138;
  localparam logic [9:0] IDX_PWD0     = 10'h139;
  localparam logic [9:0] IDX_PWD2     = 10'h13B;
  localparam logic [9:0] IDX_MASK0    = 10'h15C;
  localparam logic [9:0] IDX_MASK3    = 10'h15F;
  localparam logic [9:0] IDX_PAT_PTR  = 10'h160;
  localparam logic [9:0] IDX_PAT_DATA = 10'h161;

  // Field positions
  localparam int BMC_DETACH_BIT = 10;
  localparam int CFG_MAGIC_EN   = 0;
  localparam int CFG_PAT_EN     = 1;
  localparam int CFG_SECURE_EN  = 2;
  localparam int CFG_GPIO_SEL   = 3;
  localparam int STS_MAGIC      = 0;
  localparam int STS_PAT        = 1;
  localparam int STS_CRC_BAD    = 2;
  localparam int STS_W          = 3;

  // Reset values
  localparam logic [15:0] BMC_RST = 16'h0000;
  localparam logic [15:0] CFG_RST = 16'h0000;

  // Magic sequence geometry
  localparam logic [7:0] SYNC_BYTE = 8'hFF;
  localparam logic [2:0] SYNC_LEN  = 3'd6;
  localparam logic [2:0] ADDR_LEN  = 3'd6;
  localparam logic [3:0] ADDR_REPS = 4'd15;  // last repetition index
  localparam logic [2:0] PWD_LEN   = 3'd6;
  localparam int         PAT_BYTES = 64;

  // Frame check sequence, reflected form
  localparam logic [31:0] CRC_INIT    = 32'hFFFF_FFFF;
  localparam logic [31:0] CRC_POLY    = 32'hEDB8_8320;
  localparam logic [31:0] CRC_RESIDUE = 32'hDEBB_20E3;

  // One received byte slot
  typedef struct packed {
    logic       frame;  // high from first to last byte incl. FCS
    logic       stb;    // one-cycle strobe, data valid
    logic [7:0] data;
  } wk_rx_t;

  // Magic matcher states, Gray along the path
  typedef enum logic [1:0] {
    MS_SYNC = 2'b00,
    MS_ADDR = 2'b01,
    MS_PASS = 2'b11,
    MS_DONE = 2'b10
  } wk_mstate_t;

  // Pick byte i of a 48-bit value, byte 0 first on the wire
  function automatic logic [7:0] wk_sel_byte(input logic [47:0] v, input logic [2:0] i);
    return v[i*8 +: 8];
  endfunction

endpackage

// ===== hw/wk_crc32.sv
// Running frame check over received bytes
`timescale 1ns/100ps
module wk_crc32
  import wk_pkg::*;
(
  input  wire logic       clk,      // Clock
  input  wire logic       rst_n,    // Async reset, active low
  input  wire logic       clear,    // Frame start, restart the sum
  input  wire logic       stb,      // Byte strobe
  input  wire logic [7:0] data,     // Byte
  output logic            good      // Residue matches
);

  logic [31:0] crc_reg;
  logic [31:0] crc_next;

  // Bitwise update, one byte per strobe
  always_comb begin
    logic [31:0] c;
    c = clear ? CRC_INIT : crc_reg;
    if (stb) begin
      c = c ^ {24'h00_0000, data};
      for (int b = 0; b < 8; b++) begin
        c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
      end
    end
    crc_next = c;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      crc_reg <= CRC_INIT;
    end else begin
      crc_reg <= crc_next;
    end
  end

  assign good = (crc_reg == CRC_RESIDUE);

endmodule

// ===== hw/wk_pat_mem.sv
// Pattern byte memory with registered read data
`timescale 1ns/100ps
module wk_pat_mem #(
  parameter int DEPTH = 64,
  parameter int AW    = 6
) (
  input  wire logic          clk,    // Clock
  input  wire logic          we,     // Write strobe
  input  wire logic [AW-1:0] waddr,  // Write address
  input  wire logic [7:0]    wdata,  // Write byte
  input  wire logic [AW-1:0] raddr,  // Read address
  output logic      [7:0]    rdata   // Registered read byte
);

  logic [7:0] mem [DEPTH];

  // No reset on the array, software loads it before enabling
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule

// ===== hw/wk_detect.sv
// Wake packet detector: APB registers, magic and pattern matching
//
// Behaviour
// - Raise the wake interrupt to the MAC on a qualifying packet when enabled.
// - Optionally signal the wake on a general-purpose output instead.
// - Detach bit 10 of basic mode control suppresses the wake interrupt.
// - Matching works per byte strobe, so at every line speed.
// - A frame with a bad frame check never wakes.
// - Secure-on password must match when security is enabled.
// - One 64-byte masked pattern wakes like a magic packet.
// - Every frame addressed to this station is scanned in magic mode.
// - Only unicast frames qualify; group-address frames never wake.
// - Station address repeated sixteen times without break; a break disqualifies.
// - With security enabled the password follows the sixteenth copy directly.
// - The sequence may start at any byte of the frame.
// - Six consecutive all-ones sync bytes must precede the copies.
// - Station address lives in three writable registers.
// - Password lives in three writable registers.
`timescale 1ns/100ps
module wk_detect
  import wk_pkg::*;
#(
  parameter int PAT_LEN = PAT_BYTES
) (
  input  wire logic              pclk,     // Clock, 100 MHz
  input  wire logic              presetn,  // Async reset, active low
  input  wire logic              psel,     // APB select
  input  wire logic              penable,  // APB access phase
  input  wire logic              pwrite,   // APB direction
  input  wire logic [ADDR_W-1:0] paddr,    // APB byte address
  input  wire logic [DATA_W-1:0] pwdata,   // APB write data
  output logic      [DATA_W-1:0] prdata,   // APB read data
  output logic                   pready,   // APB ready
  output logic                   pslverr,  // APB error
  input  wire wk_rx_t            rx,       // Received byte stream
  output logic                   wake_int, // Wake interrupt to MAC
  output logic                   wake_gpio // Wake on GPIO pin
);

  localparam int AW = $clog2(PAT_LEN);

  // Mask registers only cover 64 bytes
  if (PAT_LEN < 2 || PAT_LEN > PAT_BYTES) begin : g_bad_len
    $error("PAT_LEN must lie in 2..64");
  end

  // ---------------- APB register state ----------------
  logic [15:0]       bmc_reg, bmc_next;
  logic [15:0]       cfg_reg, cfg_next;
  logic [STS_W-1:0]  sts_reg, sts_next;
  logic [47:0]       sta_reg, sta_next;
  logic [47:0]       pwd_reg, pwd_next;
  logic [63:0]       mask_reg, mask_next;
  logic [5:0]        ptr_reg, ptr_next;
  logic [DATA_W-1:0] prdata_reg, prdata_next;
  logic              pready_reg, pready_next;
  logic              pslverr_reg, pslverr_next;
  logic              int_reg, int_next;
  logic              gpio_reg, gpio_next;

  // ---------------- Frame state ----------------
  wk_mstate_t  ms_reg, ms_next;
  logic [2:0]  cnt_reg, cnt_next;
  logic [3:0]  rep_reg, rep_next;
  logic        found_reg, found_next;
  logic        fd_reg, fd_next;
  logic [6:0]  bc_reg, bc_next;
  logic        da_ok_reg, da_ok_next;
  logic        pat_ok_reg, pat_ok_next;

  logic [9:0]  idx;
  logic        setup, acc_wr, mapped;
  logic        f_start, f_end;
  logic        crc_good;
  logic [7:0]  pat_byte;
  logic        mem_we;
  logic        magic_hit, pat_hit, crc_bad, wake_ev;
  logic [15:0] wd;
  logic        sts_clr_any;

  assign idx    = paddr[ADDR_W-1:2];
  assign wd     = pwdata[REG_W-1:0];
  assign setup  = psel & ~penable & ~pready_reg;
  assign acc_wr = psel & penable & pready_reg & pwrite & ~pslverr_reg;

  // Registered word map, aligned word addresses only
  always_comb begin
    mapped = (paddr[1:0] == 2'b00) &&
             ((idx == IDX_BMC) || (idx == IDX_RX_CFG) || (idx == IDX_RX_STS) ||
              ((idx >= IDX_STA0) && (idx <= IDX_PWD2)) ||
              ((idx >= IDX_MASK0) && (idx <= IDX_PAT_DATA)));
  end

  // Read mux, answered from the setup phase so access needs no wait
  always_comb begin
    prdata_next  = prdata_reg;
    pready_next  = setup;
    pslverr_next = setup & ~mapped;
    if (setup) begin
      prdata_next = '0;
      if (mapped && !pwrite) begin
        unique case (idx)
          IDX_BMC:           prdata_next[15:0] = bmc_reg;
          IDX_RX_CFG:        prdata_next[15:0] = cfg_reg;
          IDX_RX_STS:        prdata_next[STS_W-1:0] = sts_reg;
          IDX_STA0:          prdata_next[15:0] = sta_reg[15:0];
          IDX_STA0 + 10'd1:  prdata_next[15:0] = sta_reg[31:16];
          IDX_STA2:          prdata_next[15:0] = sta_reg[47:32];
          IDX_PWD0:          prdata_next[15:0] = pwd_reg[15:0];
          IDX_PWD0 + 10'd1:  prdata_next[15:0] = pwd_reg[31:16];
          IDX_PWD2:          prdata_next[15:0] = pwd_reg[47:32];
          IDX_MASK0:         prdata_next[15:0] = mask_reg[15:0];
          IDX_MASK0 + 10'd1: prdata_next[15:0] = mask_reg[31:16];
          IDX_MASK0 + 10'd2: prdata_next[15:0] = mask_reg[47:32];
          IDX_MASK3:         prdata_next[15:0] = mask_reg[63:48];
          IDX_PAT_PTR:       prdata_next[5:0]  = ptr_reg;
          default:           prdata_next = '0;  // Pattern data is write-only
        endcase
      end
    end
  end

  // Software-written configuration
  always_comb begin
    bmc_next  = bmc_reg;
    cfg_next  = cfg_reg;
    sta_next  = sta_reg;
    pwd_next  = pwd_reg;
    mask_next = mask_reg;
    ptr_next  = ptr_reg;
    mem_we    = 1'b0;
    if (acc_wr) begin
      unique case (idx)
        IDX_BMC:           bmc_next = wd;
        IDX_RX_CFG:        cfg_next = wd;
        IDX_STA0:          sta_next[15:0]  = wd;
        IDX_STA0 + 10'd1:  sta_next[31:16] = wd;
        IDX_STA2:          sta_next[47:32] = wd;
        IDX_PWD0:          pwd_next[15:0]  = wd;
        IDX_PWD0 + 10'd1:  pwd_next[31:16] = wd;
        IDX_PWD2:          pwd_next[47:32] = wd;
        IDX_MASK0:         mask_next[15:0]  = wd;
        IDX_MASK0 + 10'd1: mask_next[31:16] = wd;
        IDX_MASK0 + 10'd2: mask_next[47:32] = wd;
        IDX_MASK3:         mask_next[63:48] = wd;
        IDX_PAT_PTR:       ptr_next = wd[5:0];
        IDX_PAT_DATA: begin
          // Pointer auto-advances and wraps at pattern length
          mem_we   = 1'b1;
          ptr_next = (ptr_reg == 6'(PAT_LEN - 1)) ? 6'h00 : ptr_reg + 6'h01;
        end
        default: ;
      endcase
    end
  end

  // ---------------- Frame scanning ----------------
  assign f_start = rx.frame & ~fd_reg;
  assign f_end   = ~rx.frame & fd_reg;

  // frame check over every byte incl. FCS
  wk_crc32 u_crc (
    .clk   (pclk),
    .rst_n (presetn),
    .clear (f_start),
    .stb   (rx.stb),
    .data  (rx.data),
    .good  (crc_good)
  );

  wk_pat_mem #(
    .DEPTH (PAT_LEN),
    .AW    (AW)
  ) u_pat (
    .clk   (pclk),
    .we    (mem_we),
    .waddr (ptr_reg[AW-1:0]),
    .wdata (wd[7:0]),
    .raddr (bc_next[AW-1:0]),
    .rdata (pat_byte)
  );

  // Magic matcher; byte strobes set the pace at any speed
  always_comb begin
    wk_mstate_t st;
    logic [2:0] cnt;
    logic [3:0] rep;
    logic       fnd;
    logic       is_ff;
    st    = f_start ? MS_SYNC : ms_reg;
    cnt   = f_start ? 3'd0 : cnt_reg;
    rep   = f_start ? 4'd0 : rep_reg;
    fnd   = f_start ? 1'b0 : found_reg;
    is_ff = (rx.data == SYNC_BYTE);
    if (rx.stb && rx.frame) begin
      unique case (st)
        MS_SYNC: begin
          // six all-ones bytes in a row
          if (!is_ff) begin
            cnt = 3'd0;
          end else if (cnt == SYNC_LEN - 3'd1) begin
            st  = MS_ADDR;
            cnt = 3'd0;
            rep = 4'd0;
          end else begin
            cnt = cnt + 3'd1;
          end
        end
        MS_ADDR: begin
          // sixteen unbroken copies of the station address
          if (rx.data == wk_sel_byte(sta_reg, cnt)) begin
            if (cnt == ADDR_LEN - 3'd1) begin
              cnt = 3'd0;
              if (rep == ADDR_REPS) begin
                st  = cfg_reg[CFG_SECURE_EN] ? MS_PASS : MS_DONE;
                fnd = ~cfg_reg[CFG_SECURE_EN];
              end else begin
                rep = rep + 4'd1;
              end
            end else begin
              cnt = cnt + 3'd1;
            end
          end else if (is_ff && cnt == 3'd0 && rep == 4'd0) begin
            st = MS_ADDR;  // Longer sync run, still waiting for copies
          end else begin
            // restart sync search, this byte may open it
            st  = MS_SYNC;
            cnt = is_ff ? 3'd1 : 3'd0;
          end
        end
        MS_PASS: begin
          if (rx.data == wk_sel_byte(pwd_reg, cnt)) begin
            if (cnt == PWD_LEN - 3'd1) begin
              st  = MS_DONE;
              fnd = 1'b1;
            end else begin
              cnt = cnt + 3'd1;
            end
          end else begin
            st  = MS_SYNC;
            cnt = is_ff ? 3'd1 : 3'd0;
          end
        end
        MS_DONE: ;
        default: st = MS_SYNC;
      endcase
    end
    if (f_end) begin
      st  = MS_SYNC;
      cnt = 3'd0;
      rep = 4'd0;
      fnd = 1'b0;
    end
    ms_next    = st;
    cnt_next   = cnt;
    rep_next   = rep;
    found_next = fnd;
  end

  // Destination check and pattern compare by byte position
  always_comb begin
    logic [6:0] bc;
    logic       da;
    logic       pok;
    bc  = f_start ? 7'd0 : bc_reg;
    da  = f_start ? 1'b1 : da_ok_reg;
    pok = f_start ? 1'b1 : pat_ok_reg;
    if (rx.stb && rx.frame) begin
      // own unicast address; group bit forbids
      if (bc < 7'd6) begin
        if (rx.data != wk_sel_byte(sta_reg, bc[2:0])) begin
          da = 1'b0;
        end
        if (bc == 7'd0 && rx.data[0]) begin
          da = 1'b0;
        end
      end
      if (bc < 7'(PAT_LEN) && mask_reg[bc[5:0]] && rx.data != pat_byte) begin
        pok = 1'b0;
      end
      // Saturate, only need to know the frame reached the pattern end
      if (bc != 7'h7F) begin
        bc = bc + 7'd1;
      end
    end
    bc_next     = f_end ? 7'd0 : bc;
    da_ok_next  = da;
    pat_ok_next = pok;
    fd_next     = rx.frame;
  end

  // Verdict at frame end
  always_comb begin
    magic_hit = f_end & cfg_reg[CFG_MAGIC_EN] & found_reg & da_ok_reg & crc_good;
    // pattern wakes like the magic sequence
    pat_hit   = f_end & cfg_reg[CFG_PAT_EN] & pat_ok_reg & da_ok_reg & crc_good &
                (bc_reg >= 7'(PAT_LEN));
    crc_bad   = f_end & ~crc_good & (bc_reg != 7'd0);
    wake_ev   = magic_hit | pat_hit;
  end

  // Sticky status, write one to clear; a same-cycle event wins
  always_comb begin
    logic [STS_W-1:0] clr;
    logic [STS_W-1:0] set;
    clr = '0;
    if (acc_wr && idx == IDX_RX_STS) begin
      clr = wd[STS_W-1:0];
    end
    set = '0;
    set[STS_MAGIC]   = magic_hit;
    set[STS_PAT]     = pat_hit;
    set[STS_CRC_BAD] = crc_bad;
    sts_next    = (sts_reg & ~clr) | set;
    sts_clr_any = |clr;
  end

  // Wake outputs; level until status is cleared
  always_comb begin
    int_next  = int_reg;
    gpio_next = gpio_reg;
    if (sts_clr_any) begin
      int_next  = 1'b0;
      gpio_next = 1'b0;
    end
    if (wake_ev) begin
      int_next  = int_next | ~cfg_reg[CFG_GPIO_SEL];
      gpio_next = gpio_next | cfg_reg[CFG_GPIO_SEL];
    end
    // detached MAC interface gets no interrupt
    if (bmc_reg[BMC_DETACH_BIT]) begin
      int_next = 1'b0;
    end
  end

  // Register bank
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bmc_reg     <= BMC_RST;
      cfg_reg     <= CFG_RST;
      sts_reg     <= '0;
      sta_reg     <= '0;
      pwd_reg     <= '0;
      mask_reg    <= '0;
      ptr_reg     <= '0;
      prdata_reg  <= '0;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      int_reg     <= 1'b0;
      gpio_reg    <= 1'b0;
      ms_reg      <= MS_SYNC;
      cnt_reg     <= '0;
      rep_reg     <= '0;
      found_reg   <= 1'b0;
      fd_reg      <= 1'b0;
      bc_reg      <= '0;
      da_ok_reg   <= 1'b0;
      pat_ok_reg  <= 1'b0;
    end else begin
      bmc_reg     <= bmc_next;
      cfg_reg     <= cfg_next;
      sts_reg     <= sts_next;
      sta_reg     <= sta_next;
      pwd_reg     <= pwd_next;
      mask_reg    <= mask_next;
      ptr_reg     <= ptr_next;
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
      int_reg     <= int_next;
      gpio_reg    <= gpio_next;
      ms_reg      <= ms_next;
      cnt_reg     <= cnt_next;
      rep_reg     <= rep_next;
      found_reg   <= found_next;
      fd_reg      <= fd_next;
      bc_reg      <= bc_next;
      da_ok_reg   <= da_ok_next;
      pat_ok_reg  <= pat_ok_next;
    end
  end

  assign prdata    = prdata_reg;
  assign pready    = pready_reg;
  assign pslverr   = pslverr_reg;
  assign wake_int  = int_reg;
  assign wake_gpio = gpio_reg;

endmodule

// ===== tb/wk_detect_props.sv
// Port assertions for the wake detector
`timescale 1ns/100ps
module wk_detect_props
  import wk_pkg::*;
(
  input wire logic              pclk,      // Clock
  input wire logic              presetn,   // Reset
  input wire logic              psel,      // Select
  input wire logic              penable,   // Access
  input wire logic              pwrite,    // Direction
  input wire logic [ADDR_W-1:0] paddr,     // Address
  input wire logic [DATA_W-1:0] pwdata,    // Write data
  input wire logic [DATA_W-1:0] prdata,    // Read data
  input wire logic              pready,    // Ready
  input wire logic              pslverr,   // Error
  input wire wk_rx_t            rx,        // Bytes
  input wire logic              wake_int,  // To MAC
  input wire logic              wake_gpio  // To pin
);
  logic det_reg;
  logic det_next;
  logic clr_w;
  logic acc;

  // Mirror of the detach bit, from accepted writes
  assign acc = psel && penable && pready && pwrite && !pslverr;
  always_comb begin
    det_next = det_reg;
    if (acc && paddr == {IDX_BMC, 2'b00})
      det_next = pwdata[BMC_DETACH_BIT];
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      det_reg <= 1'b0;
    else
      det_reg <= det_next;
  end
  // Status clear in its access cycle
  assign clr_w = acc && paddr == {IDX_RX_STS, 2'b00} && pwdata[2:0] != 3'h0;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_apb_answer: assert property (psel && !penable && !pready |=> pready && penable)
    else $error("no ready after setup");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  chk_bad_addr: assert property (psel && !penable && !pready && paddr[1:0] != 2'h0
    |=> pready && pslverr && prdata == 32'h0)
    else $error("unaligned access not refused");
  chk_detach_quiet: assert property (det_reg && $past(det_reg) |-> !wake_int)
    else $error("wake interrupt while detached");
  chk_int_after_end: assert property ($rose(wake_int) && !det_reg && !$past(det_reg)
    && !$past(det_reg, 2) |-> !$past(rx.frame) && $past(rx.frame, 2))
    else $error("wake interrupt not at frame end");
  chk_gpio_after_end: assert property ($rose(wake_gpio)
    |-> !$past(rx.frame) && $past(rx.frame, 2))
    else $error("gpio wake not at frame end");
  chk_gpio_hold: assert property (wake_gpio && !clr_w |=> wake_gpio)
    else $error("gpio wake dropped early");
  chk_clear_wake: assert property (clr_w && !(!rx.frame && $past(rx.frame))
    |=> !wake_int && !wake_gpio)
    else $error("wake not cleared");
endmodule

// ===== tb/wk_station.sv
// Remote station model sending received bytes
`timescale 1ns/100ps
module wk_station
  import wk_pkg::*;
(
  input wire logic pclk,  // Clock
  output wk_rx_t   rx     // Byte stream
);
  initial rx = '0;

  // whole bytes only
  // Gap slows strobes as at lower line speeds
  task automatic send(input logic [7:0] q[$], input int gap);
    foreach (q[i]) begin
      rx <= '{1'b1, 1'b1, q[i]};
      @(posedge pclk);
      repeat (gap) begin
        rx <= '{1'b1, 1'b0, ~q[i]};
        @(posedge pclk);
      end
    end
    // Idle data flips once at frame end so stale bytes cannot match
    rx <= '{1'b0, 1'b0, ~rx.data};
    @(posedge pclk);
  endtask
endmodule

// ===== tb/wk_detect_bench.sv
// Self-checking bench for the wake detector
`timescale 1ns/100ps
module wk_detect_bench
  import wk_pkg::*;
;
  logic              pclk;
  logic              presetn;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata;
  logic [DATA_W-1:0] prdata;
  logic              pready;
  logic              pslverr;
  wk_rx_t            rx;
  logic              wake_int;
  logic              wake_gpio;
  logic [15:0]       lf;
  logic [31:0]       rv;
  logic              re;
  logic [47:0]       sta;
  logic [47:0]       pwd;
  logic [7:0]        fr[$];
  logic [7:0]        pat[$];
  int                err_count;
  int                n_tests;

  wk_detect u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx(rx), .wake_int(wake_int), .wake_gpio(wake_gpio));
  wk_station u_sta (.pclk(pclk), .rx(rx));

  // Fixed-seed shift register source
  function automatic logic [15:0] rnd();
    lf = {1'b0, lf[15:1]} ^ (lf[0] ? 16'hB400 : 16'h0000);
    return lf;
  endfunction

  // Frame check value, sent low byte first
  function automatic logic [31:0] fcs(input logic [7:0] q[$]);
    logic [31:0] c;
    c = CRC_INIT;
    foreach (q[i]) begin
      c ^= {24'h0, q[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
    end
    return ~c;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR at %0t: seen %h, expected %h", $time, got, exp);
    end
  endtask

  // One bus transfer; waits for ready, only the watchdog ends a hang
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rv = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [9:0] ix, input logic [31:0] d);
    apb(1'b1, {ix, 2'b00}, d);
  endtask

  task automatic rdc(input logic [9:0] ix, input logic [31:0] exp);
    apb(1'b0, {ix, 2'b00}, 32'h0);
    chk(rv, exp);
  endtask

  // Kinds: 0 good, 1 bad check, 2 broken copy, 3 short sync,
  // 4 broadcast, 6 wrong password, 10/11 pattern with a changed byte
  task automatic build(input int k);
    logic [31:0] c;
    fr = {};
    if (k >= 10) begin
      fr = pat;
      fr[k == 10 ? 10 : 20] ^= 8'h5A;
    end else begin
      for (int i = 0; i < 6; i++) fr.push_back(k == 4 ? 8'hFF : sta[i*8 +: 8]);
      repeat (6 + rnd() % 8) fr.push_back(8'(rnd()) & 8'h7F);
      repeat (k == 3 ? 5 : 6) fr.push_back(8'hFF);
      for (int n = 0; n < 96; n++)
        fr.push_back(sta[(n % 6)*8 +: 8] ^ (k == 2 && n == 57 ? 8'h10 : 8'h00));
      for (int i = 0; i < 6; i++) fr.push_back(pwd[i*8 +: 8] ^ (k == 6 ? 8'h01 : 8'h00));
      fr.push_back(8'h00);
    end
    c = fcs(fr) ^ (k == 1 ? 32'h1 : 32'h0);
    for (int i = 0; i < 4; i++) fr.push_back(c[i*8 +: 8]);
  endtask

  // Send one frame, check outputs and status, then clear
  task automatic runf(input int k, input logic ei, input logic eg, input logic [2:0] es);
    build(k);
    u_sta.send(fr, int'(rnd() % 4));
    @(posedge pclk);
    chk(32'(wake_int), 32'(ei));
    chk(32'(wake_gpio), 32'(eg));
    rdc(IDX_RX_STS, 32'(es));
    wr(IDX_RX_STS, 32'h7);
    $display("frame kind %0d done", k);
  endtask

  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Longest run is a few thousand cycles; far beyond means a hang
  initial begin
    repeat (80000) @(posedge pclk);
    err_count++;
    conclude();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    lf = 16'h281A;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(IDX_BMC, 32'h0);
    rdc(IDX_RX_CFG, 32'h0);
    rdc(IDX_RX_STS, 32'h0);
    apb(1'b0, 12'h004, 32'h0);
    chk(32'(re), 32'h1);
    apb(1'b0, 12'h4D2, 32'h0);
    chk(32'(re), 32'h1);
    $display("register checks done");
    // Station address must be unicast for frames to reach us
    sta = {rnd(), rnd(), rnd()} & ~48'h1;
    pwd = {rnd(), rnd(), rnd()};
    for (int i = 0; i < 3; i++) begin
      wr(IDX_STA0 + 10'(i), {16'h0, sta[i*16 +: 16]});
      wr(IDX_PWD0 + 10'(i), {16'h0, pwd[i*16 +: 16]});
    end
    rdc(IDX_STA2, {16'h0, sta[47:32]});
    rdc(IDX_PWD2, {16'h0, pwd[47:32]});
    wr(IDX_RX_CFG, 32'h1);
    runf(0, 1'b1, 1'b0, 3'h1);
    runf(1, 1'b0, 1'b0, 3'h4);
    runf(2, 1'b0, 1'b0, 3'h0);
    runf(3, 1'b0, 1'b0, 3'h0);
    runf(4, 1'b0, 1'b0, 3'h0);
    // Group bit programmed into our own address: still no wake
    sta[0] = 1'b1;
    wr(IDX_STA0, {16'h0, sta[15:0]});
    runf(0, 1'b0, 1'b0, 3'h0);
    sta[0] = 1'b0;
    wr(IDX_STA0, {16'h0, sta[15:0]});
    wr(IDX_RX_CFG, 32'h5);
    runf(0, 1'b1, 1'b0, 3'h1);
    runf(6, 1'b0, 1'b0, 3'h0);
    wr(IDX_RX_CFG, 32'h9);
    runf(0, 1'b0, 1'b1, 3'h1);
    wr(IDX_RX_CFG, 32'h1);
    wr(IDX_BMC, 32'h400);
    runf(0, 1'b0, 1'b0, 3'h1);
    wr(IDX_BMC, 32'h0);
    // Pattern starts with our address; byte 10 left unmasked
    pat = {};
    for (int i = 0; i < PAT_BYTES; i++) pat.push_back(i < 6 ? sta[i*8 +: 8] : 8'(rnd()));
    wr(IDX_PAT_PTR, 32'h0);
    foreach (pat[i]) wr(IDX_PAT_DATA, {24'h0, pat[i]});
    wr(IDX_MASK0, 32'hFBFF);
    for (int i = 1; i < 4; i++) wr(IDX_MASK0 + 10'(i), 32'hFFFF);
    wr(IDX_RX_CFG, 32'h2);
    runf(10, 1'b1, 1'b0, 3'h2);
    runf(11, 1'b0, 1'b0, 3'h0);
    conclude();
  end
endmodule

bind wk_detect wk_detect_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .rx(rx), .wake_int(wake_int), .wake_gpio(wake_gpio));
